// ===== design/seq_pkg.sv
// constants for the standby, wake and boot sequencer
// assumes a 250 MHz sequencer clock and a byte-wide boot copy path
package seq_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned BOOT_FIXED_US = 2000;
	localparam int unsigned BOOT_PER_KB_US = 3600;
	localparam int unsigned BOOT_FIXED_CYC = BOOT_FIXED_US * CLK_MHZ;
	localparam int unsigned BOOT_PER_KB_CYC = BOOT_PER_KB_US * CLK_MHZ;
	localparam int unsigned RAM_BYTES = 4096;
	localparam int unsigned KB_BYTES = 1024;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned SLEEP_MAX_S = 6800;
	localparam int unsigned SLEEP_W = 32;
	localparam int unsigned GPIO_N = 9;
	localparam int unsigned DIV_SEL_W = 3;
	localparam int unsigned DIV_W = 7;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned FREQ_W = 24;
	localparam int unsigned RET_BYTES = 8;
	localparam int unsigned PERIPH_N = 8;
	localparam logic [PERIPH_N-1:0] PERIPH_RST = 8'h00;
	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,
		ST_WAKE = 3'b001,
		ST_BOOT = 3'b011,
		ST_RUN = 3'b010,
		ST_XTAL = 3'b110,
		ST_TX = 3'b111
	} seq_state_t;
endpackage : seq_pkg

// ===== design/retention_ram.sv
// small always-on retention memory
// assumes its supply stays up while the battery is present; registered read data
`timescale 1ns/10ps
module retention_ram #(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned AW = 3
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0] rd;
	} ram_t;
	ram_t r_q, r_d;
	always_comb begin
		r_d = r_q;
		if (we_i) begin
			r_d.mem[addr_i] = wdata_i;
		end
		r_d.rd = r_q.mem[addr_i];
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r_q <= '0;
		end else if (clk_en_i) begin
			r_q <= r_d;
		end
	end
	assign rdata_o = r_q.rd;
endmodule : retention_ram

// ===== design/standby_wake_boot_sequencer.sv
// standby, wake and boot sequencer with clock and power-down control
// assumes arst_n_i is the power-on reset; gpio and sleep tick pins are asynchronous
`timescale 1ns/10ps
module standby_wake_boot_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned FIXED_CYC = BOOT_FIXED_CYC,
	parameter int unsigned PER_KB_CYC = BOOT_PER_KB_CYC,
	parameter int unsigned IMG_BYTES = RAM_BYTES
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic [seq_pkg::GPIO_N-1:0] gpio_i,
	input wire logic sleep_tick_i,
	input wire logic [seq_pkg::SLEEP_W-1:0] sleep_interval_i,
	input wire logic sleep_en_i,
	input wire logic standby_req_i,
	output logic [seq_pkg::ADDR_W-1:0] boot_addr_o,
	output logic boot_rd_o,
	input wire logic [7:0] boot_rdata_i,
	output logic ram_we_o,
	output logic [seq_pkg::ADDR_W-1:0] ram_addr_o,
	output logic [7:0] ram_wdata_o,
	output logic core_rst_n_o,
	output logic core_osc_en_o,
	input wire logic [seq_pkg::DIV_SEL_W-1:0] clk_div_sel_i,
	output logic sys_clk_en_o,
	output logic timer_clk_en_o,
	input wire logic xtal_en_i,
	input wire logic tx_req_i,
	input wire logic xtal_ref_i,
	input wire logic carrier_ref_i,
	input wire logic [seq_pkg::FREQ_W-1:0] cal_window_i,
	output logic [seq_pkg::FREQ_W-1:0] cal_count_o,
	output logic cal_done_o,
	output logic xtal_osc_en_o,
	input wire logic tx_done_i,
	input wire logic ser_active_i,
	output logic carrier_osc_en_o,
	output logic carrier_div_en_o,
	output logic pa_en_o,
	input wire logic analog_used_i,
	output logic ref_gen_en_o,
	input wire logic [seq_pkg::PERIPH_N-1:0] periph_off_i,
	output logic [seq_pkg::PERIPH_N-1:0] periph_en_o,
	input wire logic ret_we_i,
	input wire logic [2:0] ret_addr_i,
	input wire logic [7:0] ret_wdata_i,
	output logic [7:0] ret_rdata_o,
	output logic awake_o,
	output logic [2:0] state_o
);
	import seq_pkg::*;

	typedef struct packed {
		seq_state_t st;
		logic [1:0] g0, g1, g2;
		logic [GPIO_N-1:0] gs0, gs1, gprev;
		logic [2:0] ts;
		logic [2:0] xs;
		logic [2:0] cs;
		logic [SLEEP_W-1:0] sleep_cnt;
		logic [CNT_W-1:0] wait_cnt;
		logic [ADDR_W:0] addr;
		logic [CNT_W-1:0] kb_cnt;
		logic rd_pend;
		logic [ADDR_W-1:0] rd_addr;
		logic we;
		logic [ADDR_W-1:0] waddr;
		logic [7:0] wdata;
		logic [DIV_W-1:0] div_cnt;
		logic sys_en;
		logic [FREQ_W-1:0] win_cnt, ratio;
		logic cal_run, cal_done;
	} seq_t;

	seq_t s_q, s_d;
	logic gpio_fall;
	logic sleep_pulse;
	logic [DIV_W-1:0] div_mask;

	always_comb begin
		s_d = s_q;
		s_d.gs0 = gpio_i;
		s_d.gs1 = s_q.gs0;
		s_d.gprev = s_q.gs1;
		s_d.ts = {s_q.ts[1:0], sleep_tick_i};
		s_d.xs = {s_q.xs[1:0], xtal_ref_i};
		s_d.cs = {s_q.cs[1:0], carrier_ref_i};
		s_d.g0 = '0;
		s_d.g1 = '0;
		s_d.g2 = '0;
		s_d.we = 1'b0;
		gpio_fall = |(s_q.gprev & ~s_q.gs1);
		sleep_pulse = s_q.ts[1] & ~s_q.ts[2];
		div_mask = DIV_W'((8'h01 << clk_div_sel_i) - 8'h01);
		// divider runs only while the core is clocked; a pulse every 2^sel cycles
		if (s_q.st != ST_STANDBY) begin
			s_d.div_cnt = DIV_W'(s_q.div_cnt + 1'b1);
			s_d.sys_en = ((s_q.div_cnt & div_mask) == '0);
		end else begin
			s_d.div_cnt = '0;
			s_d.sys_en = 1'b0;
		end
		unique case (s_q.st)
			ST_STANDBY: begin
				// sleep counter counts slow ticks; zero interval disables it
				if (sleep_en_i && sleep_interval_i != '0 && sleep_pulse) begin
					s_d.sleep_cnt = SLEEP_W'(s_q.sleep_cnt + 1'b1);
				end
				if (gpio_fall) begin
					s_d.st = ST_WAKE;
				end else if (sleep_en_i && sleep_interval_i != '0 && s_q.sleep_cnt >= sleep_interval_i) begin
					s_d.st = ST_WAKE;
				end
				if (s_d.st == ST_WAKE) begin
					s_d.sleep_cnt = '0;
					s_d.wait_cnt = '0;
					s_d.addr = '0;
					s_d.kb_cnt = '0;
					s_d.rd_pend = 1'b0;
				end
			end
			ST_WAKE: begin
				// fixed boot overhead before the first byte moves
				s_d.wait_cnt = CNT_W'(s_q.wait_cnt + 1'b1);
				if (s_q.wait_cnt >= CNT_W'(FIXED_CYC - 1)) begin
					s_d.st = ST_BOOT;
					s_d.wait_cnt = '0;
				end
			end
			ST_BOOT: begin
				// bytes are paced evenly at PER_KB_CYC / KB_BYTES cycles each, rounded down, so a kilobyte takes at most its per-kilobyte time
				s_d.kb_cnt = CNT_W'(s_q.kb_cnt + 1'b1);
				if (s_q.rd_pend) begin
					s_d.we = 1'b1;
					s_d.waddr = s_q.rd_addr;
					s_d.wdata = boot_rdata_i;
					s_d.rd_pend = 1'b0;
				end
				if (s_q.kb_cnt >= CNT_W'(PER_KB_CYC / KB_BYTES - 1)) begin
					s_d.kb_cnt = '0;
					if (s_q.addr < (ADDR_W + 1)'(IMG_BYTES)) begin
						s_d.rd_pend = 1'b1;
						s_d.rd_addr = s_q.addr[ADDR_W-1:0];
						s_d.addr = (ADDR_W + 1)'(s_q.addr + 1'b1);
					end
				end
				if (s_q.addr >= (ADDR_W + 1)'(IMG_BYTES) && !s_q.rd_pend && !s_q.we) begin
					s_d.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (standby_req_i) begin
					s_d.st = ST_STANDBY;
				end else if (tx_req_i) begin
					s_d.st = xtal_en_i ? ST_XTAL : ST_TX;
					s_d.win_cnt = '0;
					s_d.ratio = '0;
					s_d.cal_run = xtal_en_i;
					s_d.cal_done = 1'b0;
				end
			end
			ST_XTAL: begin
				// count carrier-reference edges over a window of crystal edges;
				// the window opens at the first crystal edge so entry phase does not skew the ratio
				if ((s_q.cs[1] & ~s_q.cs[2]) && s_q.win_cnt != '0) begin
					s_d.ratio = FREQ_W'(s_q.ratio + 1'b1);
				end
				if (s_q.xs[1] & ~s_q.xs[2]) begin
					s_d.win_cnt = FREQ_W'(s_q.win_cnt + 1'b1);
				end
				if (s_q.win_cnt > cal_window_i) begin
					s_d.cal_run = 1'b0;
					s_d.cal_done = 1'b1;
					s_d.st = ST_TX;
				end
			end
			ST_TX: begin
				if (tx_done_i) begin
					s_d.st = ST_RUN;
				end
			end
			default: begin
				s_d.st = ST_STANDBY;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '0;
			s_q.st <= ST_STANDBY;
			s_q.gs0 <= '1;
			s_q.gs1 <= '1;
			s_q.gprev <= '1;
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	retention_ram #(
		.DEPTH(RET_BYTES),
		.AW(3)
	) u_ret (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.clk_en_i(clk_en_i),
		.we_i(ret_we_i),
		.addr_i(ret_addr_i),
		.wdata_i(ret_wdata_i),
		.rdata_o(ret_rdata_o)
	);

	assign awake_o = (s_q.st != ST_STANDBY);
	assign state_o = s_q.st;
	assign boot_rd_o = (s_q.st == ST_BOOT) && (s_q.kb_cnt >= CNT_W'(PER_KB_CYC / KB_BYTES - 1))
		&& (s_q.addr < (ADDR_W + 1)'(IMG_BYTES));
	assign boot_addr_o = s_q.addr[ADDR_W-1:0];
	assign ram_we_o = s_q.we;
	assign ram_addr_o = s_q.waddr;
	assign ram_wdata_o = s_q.wdata;
	assign core_rst_n_o = (s_q.st == ST_RUN) || (s_q.st == ST_XTAL) || (s_q.st == ST_TX);
	assign core_osc_en_o = awake_o;
	assign sys_clk_en_o = s_q.sys_en & core_rst_n_o;
	assign timer_clk_en_o = awake_o;
	assign xtal_osc_en_o = (s_q.st == ST_XTAL) && s_q.cal_run;
	assign cal_count_o = s_q.ratio;
	assign cal_done_o = s_q.cal_done;
	// serializer activity gates each stage; carrier, divider and amplifier all switch on together in the same cycle
	assign carrier_osc_en_o = (s_q.st == ST_TX) && ser_active_i;
	assign carrier_div_en_o = (s_q.st == ST_TX) && ser_active_i;
	assign pa_en_o = (s_q.st == ST_TX) && ser_active_i;
	assign ref_gen_en_o = awake_o && (analog_used_i || s_q.st == ST_XTAL || s_q.st == ST_TX);
	assign periph_en_o = awake_o ? ~periph_off_i : PERIPH_RST;
endmodule : standby_wake_boot_sequencer

// ===== verif/standby_wake_boot_sequencer_chk.sv
// checker for the standby, wake and boot sequencer
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module standby_wake_boot_sequencer_chk (
	input wire logic ref_clk_i, arst_n_i, boot_rd_o, ram_we_o, core_rst_n_o, core_osc_en_o, timer_clk_en_o,
	input wire logic sys_clk_en_o, xtal_osc_en_o, ser_active_i, carrier_osc_en_o, carrier_div_en_o, pa_en_o,
	input wire logic analog_used_i, ref_gen_en_o, awake_o, cal_done_o,
	input wire logic [8:0] gpio_i,
	input wire logic [7:0] boot_rdata_i, ram_wdata_o, periph_off_i, periph_en_o,
	input wire logic [11:0] boot_addr_o, ram_addr_o,
	input wire logic [2:0] clk_div_sel_i, state_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	a_core_held: assert property (state_o inside {3'h0, 3'h1, 3'h3} |-> !core_rst_n_o)
		else $error("core released before boot done");
	a_run_free: assert property (state_o == 3'h2 |-> core_rst_n_o)
		else $error("core held in run");
	a_standby_dark: assert property (state_o == 3'h0 |-> !core_osc_en_o && !timer_clk_en_o
		&& periph_en_o == 8'h00 && !ref_gen_en_o && !xtal_osc_en_o) else $error("block powered in standby");
	a_osc_awake: assert property (awake_o |-> core_osc_en_o && timer_clk_en_o)
		else $error("core clock off while awake");
	a_gpio_wake: assert property (state_o == 3'h0 && |($past(gpio_i) & ~gpio_i) |-> ##[1:4] state_o == 3'h1)
		else $error("pin fall did not wake");
	a_copy_order: assert property (boot_rd_o |-> ##2 ram_we_o && ram_addr_o == $past(boot_addr_o, 2)
		&& ram_wdata_o == $past(boot_rdata_i)) else $error("boot byte not copied");
	a_xtal_window: assert property (xtal_osc_en_o |-> state_o == 3'h6)
		else $error("crystal on outside measurement");
	a_pa_sched: assert property ({carrier_osc_en_o, carrier_div_en_o, pa_en_o} == {3{state_o == 3'h7 && ser_active_i}})
		else $error("transmit power enables wrong");
	a_ref_gate: assert property (ref_gen_en_o == (awake_o && (analog_used_i || state_o[2])))
		else $error("reference enable wrong");
	a_div_gap: assert property (sys_clk_en_o && clk_div_sel_i != 3'h0 && $stable(clk_div_sel_i)
		##1 $stable(clk_div_sel_i) |-> !sys_clk_en_o) else $error("divided clock pulses too close");
	a_periph_mask: assert property (awake_o |-> periph_en_o == ~periph_off_i)
		else $error("peripheral enable wrong");
	c_boot_done: cover property (state_o == 3'h3 ##1 state_o == 3'h2);
	c_tx: cover property (pa_en_o);
	c_cal: cover property ($rose(cal_done_o));
endmodule : standby_wake_boot_sequencer_chk
bind standby_wake_boot_sequencer standby_wake_boot_sequencer_chk u_chk (.*);

// ===== verif/boot_mem.sv
// model of the one-time-programmable boot memory
// assumes a read pulse with the address; data shows the cycle after
`timescale 1ns/10ps
module boot_mem (
	input wire logic ref_clk_i,
	input wire logic boot_rd_o,
	input wire logic [11:0] boot_addr_o,
	output logic [7:0] boot_rdata_i
);
	initial boot_rdata_i = 8'h00;
	// outside a read the data flips, so a stale sample never matches
	always @(posedge ref_clk_i) boot_rdata_i <= boot_rd_o ? (boot_addr_o[7:0] ^ 8'hA5) : ~boot_rdata_i;
endmodule : boot_mem

// ===== verif/standby_wake_boot_sequencer_tb.sv
// self-checking bench for the standby, wake and boot sequencer
// assumes the boot memory model and a shortened boot: 10 fixed cycles, 16 bytes of 4 cycles
`timescale 1ns/10ps
module standby_wake_boot_sequencer_tb;
	logic ref_clk_i = 0, arst_n_i = 0, clk_en_i = 1, sleep_tick_i = 0, sleep_en_i = 0, standby_req_i = 0;
	logic xtal_en_i = 0, tx_req_i = 0, xtal_ref_i = 0, carrier_ref_i = 0, tx_done_i = 0, ser_active_i = 0;
	logic analog_used_i = 0, ret_we_i = 0, boot_rd_o, ram_we_o, core_rst_n_o, core_osc_en_o, sys_clk_en_o;
	logic timer_clk_en_o, cal_done_o, xtal_osc_en_o, carrier_osc_en_o, carrier_div_en_o, pa_en_o, ref_gen_en_o, awake_o;
	logic [8:0] gpio_i = 9'h1FF;
	logic [31:0] sleep_interval_i = 32'h0;
	logic [11:0] boot_addr_o, ram_addr_o;
	logic [7:0] boot_rdata_i, ram_wdata_o, ret_rdata_o, periph_en_o, ret_wdata_i = 8'h00, periph_off_i = 8'h00;
	logic [2:0] clk_div_sel_i = 3'h0, ret_addr_i = 3'h0, state_o;
	logic [23:0] cal_window_i = 24'h4, cal_count_o;
	int num_errors = 0, cmp_count = 0;
	standby_wake_boot_sequencer #(.FIXED_CYC(10), .PER_KB_CYC(4096), .IMG_BYTES(16)) u_dut (.*);
	boot_mem u_mem (.ref_clk_i, .boot_rd_o, .boot_addr_o, .boot_rdata_i);
	always #2 ref_clk_i = ~ref_clk_i;
	// slow references keep the sampled edges free of aliasing
	always #23.3 xtal_ref_i = ~xtal_ref_i;
	always #9.7 carrier_ref_i = ~carrier_ref_i;
	task automatic stop_test;
		if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %0t got %0h exp %0h", $time, g, e);
		end
	endtask : ck
	task automatic wt(input logic [2:0] s);
		int n = 0;
		while (state_o !== s) begin
			@(negedge ref_clk_i);
			if (++n > 3000) begin
				ck(state_o, s);
				stop_test;
			end
		end
	endtask : wt
	task automatic t_boot;
		int n = 0, w = 0;
		gpio_i[4] = 1'b0;
		while (state_o !== 3'h2 && n < 3000) begin
			@(posedge ref_clk_i);
			#1;
			if (ram_we_o === 1'b1) begin
				ck(ram_wdata_o, ram_addr_o[7:0] ^ 8'hA5);
				ck(ram_addr_o, w++);
			end
			n++;
		end
		if (n >= 3000) begin
			ck(state_o, 3'h2);
			stop_test;
		end
		@(negedge ref_clk_i);
		gpio_i[4] = 1'b1;
		ck(w, 16);
		ck(n >= 74 && n <= 90, 1);
		ck(core_rst_n_o, 1);
	endtask : t_boot
	task automatic t_run;
		int c;
		periph_off_i = 8'h5A;
		analog_used_i = 1'b1;
		for (int s = 0; s < 8; s++) begin
			clk_div_sel_i = 3'(s);
			c = 0;
			repeat (140) @(negedge ref_clk_i);
			repeat (128) begin
				@(negedge ref_clk_i);
				if (sys_clk_en_o === 1'b1) c++;
			end
			ck(c, 128 >> s);
		end
		ck(periph_en_o, 8'hA5);
		ck(ref_gen_en_o, 1);
		analog_used_i = 1'b0;
	endtask : t_run
	task automatic t_tx;
		xtal_en_i = 1'b1;
		tx_req_i = 1'b1;
		wt(3'h6);
		ck(xtal_osc_en_o, 1);
		wt(3'h7);
		tx_req_i = 1'b0;
		ck(cal_done_o, 1);
		ck(cal_count_o >= 8 && cal_count_o <= 11, 1);
		ck(xtal_osc_en_o, 0);
		ser_active_i = 1'b1;
		@(negedge ref_clk_i);
		ck({carrier_osc_en_o, carrier_div_en_o, pa_en_o}, 3'h7);
		ser_active_i = 1'b0;
		tx_done_i = 1'b1;
		wt(3'h2);
		tx_done_i = 1'b0;
		xtal_en_i = 1'b0;
	endtask : t_tx
	task automatic t_sleep;
		ret_we_i = 1'b1;
		ret_addr_i = 3'h5;
		ret_wdata_i = 8'h3C;
		@(negedge ref_clk_i);
		ret_we_i = 1'b0;
		standby_req_i = 1'b1;
		wt(3'h0);
		standby_req_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		ck(ret_rdata_o, 8'h3C);
		ck(core_osc_en_o, 0);
		sleep_interval_i = 32'h3;
		sleep_en_i = 1'b1;
		for (int i = 0; i < 3; i++) begin
			ck(state_o, 0);
			sleep_tick_i = 1'b1;
			repeat (4) @(negedge ref_clk_i);
			sleep_tick_i = 1'b0;
			repeat (4) @(negedge ref_clk_i);
		end
		wt(3'h2);
		sleep_en_i = 1'b0;
		ck(core_rst_n_o, 1);
	endtask : t_sleep
	initial begin
		repeat (10) @(negedge ref_clk_i);
		ck(state_o, 0);
		ck(core_rst_n_o, 0);
		arst_n_i = 1'b1;
		repeat (5) @(negedge ref_clk_i);
		ck(state_o, 0);
		t_boot;
		t_run;
		t_tx;
		t_sleep;
		stop_test;
	end
endmodule : standby_wake_boot_sequencer_tb
